// ==== core/codec_pkg.sv ====
// Purpose: Shared constants for the codec digital core
// Assumes: 50 MHz system clock
// Notes:   Capture modes, routing codes, timing counts
package codec_pkg;
    localparam int          WORD_W        = 10;
    localparam int          ROUTE_W       = 4;
    localparam int          NUM_CONV      = 4;
    localparam int          OVL_W         = 3;
    localparam int          ADC_W         = 12;
    localparam int          TRIM_W        = 2;
    localparam int          AUX_DIV       = 32;
    localparam int          AUX_CNT_W     = 5;
    localparam int          CLK_MHZ       = 50;
    localparam int          ADC_MAX_MHZ   = 54;
    localparam int          DAC_MULTI_MHZ = 54;
    localparam int          DAC_SINGLE_MHZ = 200;

    typedef enum logic [1:0]
    {
        CAP_OFF   = 2'b00,
        CAP_SINGLE = 2'b01,
        CAP_DUAL  = 2'b10,
        CAP_422   = 2'b11
    } cap_mode_t;

    localparam logic [3:0] RT_CV1   = 4'h0;
    localparam logic [3:0] RT_CV2   = 4'h1;
    localparam logic [3:0] RT_CV3   = 4'h2;
    localparam logic [3:0] RT_RSVD  = 4'h3;
    localparam logic [3:0] RT_CV5   = 4'h4;
    localparam logic [3:0] RT_CV6   = 4'h5;
    localparam logic [3:0] RT_YC14  = 4'h6;
    localparam logic [3:0] RT_YC23  = 4'h7;
    localparam logic [3:0] RT_YUV   = 4'h8;
    localparam logic [3:0] RT_AUX1  = 4'h9;
    localparam logic [3:0] RT_AUX2  = 4'ha;

    // Routing output kinds
    localparam logic [1:0] ST_CVBS  = 2'h0;
    localparam logic [1:0] ST_YC    = 2'h1;
    localparam logic [1:0] ST_YUV   = 2'h2;
    localparam logic [1:0] ST_NONE  = 2'h3;

    localparam logic [1:0] CONV0 = 2'h0;
    localparam logic [1:0] CONV1 = 2'h1;
    localparam logic [1:0] CONV2 = 2'h2;
    localparam logic [1:0] CONV3 = 2'h3;
endpackage

// ==== core/conv_bus_if.sv ====
// Purpose: Carries captured words into the converter steering block
// Assumes: One clock domain
// Notes:   Write strobe per converter
`timescale 1ns/10ps
interface conv_bus_if;
    logic [3:0] wr;
    logic [9:0] word [4];

    modport src (output wr, output word);
    modport dst (input wr, input word);
endinterface

// ==== core/conv_latch.sv ====
// Purpose: Holds one word per output converter and the overlay mux
// Assumes: Synchronous reset copy from the top
// Notes:   Overlay replaces all ten bits of converters 0..2
`timescale 1ns/10ps
module conv_latch
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Captured words
    conv_bus_if.dst          cb,
    // Overlay
    input  wire logic [2:0]  ovl_in,
    input  wire logic        ovl_en,
    // Converter codes
    output logic [9:0]       conv_out [4]
);
    genvar g;
    generate
        for (g = 0; g < codec_pkg::NUM_CONV; g++)
        begin : g_conv
            logic [9:0] hold_reg;
            logic [9:0] sel;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    hold_reg <= 10'h000;
                else if (cb.wr[g])
                    hold_reg <= cb.word[g];
            end
            // Overlay full scale on converters 0..2
            if (g < codec_pkg::OVL_W)
            begin : g_ovl
                assign sel = ovl_en ? {10{ovl_in[g]}} : hold_reg;
            end
            else
            begin : g_plain
                assign sel = hold_reg;
            end
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    conv_out[g] <= 10'h000;
                else
                    conv_out[g] <= sel;
            end
        end
    endgenerate
endmodule

// ==== core/video_codec_core.sv ====
// Purpose: Capture, steering, routing decode and output flags of a video codec
// Assumes: Capture, overlay and master clock pins are sampled on clk through two flip-flops
// Notes:   Mode and routing code are plain ports in place of serial registers
//
// Behaviour
// - Converter words are ten bits; capture mode picks one of three.
// - Mode 1 latches only on strobe clock rising edge; marker is a sync flag.
// - Mode 1 marker high marks converter 0 word; next words go onward.
// - Mode 2 latches on both edges of both strobes, four converters.
// - Mode 3 takes 4:2:2 on strobe clock; marker high marks red difference.
// - Mode 3 luma to converter 1, red to 2, blue to 0.
// - Codes 0000-0101 select single composite; 0011 reserved.
// - Codes 0110, 0111 select Y/C input pairs.
// - Code 1000 selects component on channels 2, 3, 6 with three paths.
// - Codes 1001, 1010 select composite plus auxiliary inputs 3 to 6.
// - Auxiliary sample tick is master clock divided by 32.
// - Digitizer is 12 bits with 2 trim bits, up to 54 MHz.
// - Digitized words leave on the output bus at master clock rise.
// - Chroma flag high while red or chroma sample is on output bus.
// - Converters take 54 MHz multi, 200 MHz with converter 0 only.
// - Three overlay inputs multiplex onto converter outputs 0 to 2.
// - Overlay switched in only while overlay enable is high.
`timescale 1ns/10ps
module video_codec_core
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Configuration
    input  wire logic [1:0]  cap_mode,
    input  wire logic [3:0]  route_code,
    // Capture pins
    input  wire logic [9:0]  conv_data,
    input  wire logic        capture_strobe_clock,
    input  wire logic        capture_marker_line,
    // Overlay pins
    input  wire logic [2:0]  overlay_inputs,
    input  wire logic        overlay_enable,
    // Digitizer side
    input  wire logic        master_clock_pin,
    input  wire logic [11:0] adc_sample,
    input  wire logic        adc_chroma,
    // Converter codes
    output logic [9:0]       output_converter_0,
    output logic [9:0]       output_converter_1,
    output logic [9:0]       output_converter_2,
    output logic [9:0]       output_converter_3,
    output logic             conv0_only,
    // Routing decode
    output logic [5:0]       channel_enable,
    output logic [5:0]       channel_single_ended,
    output logic [2:0]       sha_enable,
    output logic             route_reserved,
    output logic             aux_enable,
    output logic             aux_tick,
    // Digitizer output
    output logic [9:0]       dout,
    output logic             chroma_phase
);
    ////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    wire rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: data, strobes, master clock
    localparam int SW = codec_pkg::OVL_W + codec_pkg::WORD_W + 4;
    logic [SW-1:0] s1_reg, s2_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
        end
        else
        begin
            s1_reg <= {overlay_enable, overlay_inputs, conv_data,
                       capture_strobe_clock, capture_marker_line, master_clock_pin};
            s2_reg <= s1_reg;
        end
    end
    wire       ovl_en_s = s2_reg[16];
    wire [2:0] ovl_s    = s2_reg[15:13];
    wire [9:0] d_s      = s2_reg[12:3];
    wire       sclk     = s2_reg[2];
    wire       mark     = s2_reg[1];
    wire       mclk     = s2_reg[0];
    logic [2:0] edge_d_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            edge_d_reg <= 3'h0;
        else
            edge_d_reg <= s2_reg[2:0];
    end
    wire sclk_rise = sclk & ~edge_d_reg[2];
    wire sclk_fall = ~sclk & edge_d_reg[2];
    wire mark_rise = mark & ~edge_d_reg[1];
    wire mark_fall = ~mark & edge_d_reg[1];
    wire mclk_rise = mclk & ~edge_d_reg[0];

    ////////////////////////////////////////////////////////////////////
    // Capture steering
    codec_pkg::cap_mode_t mode;
    assign mode = codec_pkg::cap_mode_t'(cap_mode);
    logic [1:0] seq_reg, seq_next;
    logic [3:0] wr;
    logic [1:0] dst;
    // Mode 3: Y, Cb, Y, Cr; marker marks Cr, so chroma alternates on marker
    wire is_luma = (seq_reg[0] == 1'b0);
    always_comb
    begin
        wr       = 4'h0;
        dst      = codec_pkg::CONV0;
        seq_next = seq_reg;
        unique case (mode)
            codec_pkg::CAP_SINGLE:
            begin
                if (sclk_rise)
                begin
                    dst      = mark ? codec_pkg::CONV0 : seq_reg;
                    wr[dst]  = 1'b1;
                    seq_next = dst + 2'h1;
                end
            end
            codec_pkg::CAP_DUAL:
            begin
                if (sclk_rise)
                    wr[codec_pkg::CONV0] = 1'b1;
                if (mark_rise)
                    wr[codec_pkg::CONV1] = 1'b1;
                if (sclk_fall)
                    wr[codec_pkg::CONV2] = 1'b1;
                if (mark_fall)
                    wr[codec_pkg::CONV3] = 1'b1;
            end
            codec_pkg::CAP_422:
            begin
                if (sclk_rise)
                begin
                    if (mark)
                        dst = codec_pkg::CONV2;
                    else if (is_luma)
                        dst = codec_pkg::CONV1;
                    else
                        dst = codec_pkg::CONV0;
                    wr[dst]  = 1'b1;
                    seq_next = mark ? 2'h0 : {1'b0, ~seq_reg[0]};
                end
            end
            codec_pkg::CAP_OFF:
            begin
                seq_next = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seq_reg <= 2'h0;
        else
            seq_reg <= seq_next;
    end
    conv_bus_if cb ();
    assign cb.wr = wr;
    genvar g;
    generate
        for (g = 0; g < codec_pkg::NUM_CONV; g++)
        begin : g_word
            assign cb.word[g] = d_s;
        end
    endgenerate

    logic [9:0] co [4];
    conv_latch u_latch
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .cb       (cb.dst),
        .ovl_in   (ovl_s),
        .ovl_en   (ovl_en_s),
        .conv_out (co)
    );
    assign output_converter_0 = co[0];
    assign output_converter_1 = co[1];
    assign output_converter_2 = co[2];
    assign output_converter_3 = co[3];

    // Only converter 0 active allows the faster rate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            conv0_only <= 1'b0;
        else
            conv0_only <= (mode == codec_pkg::CAP_OFF);
    end

    ////////////////////////////////////////////////////////////////////
    // Routing decode
    logic [5:0] ch;
    logic [5:0] se;
    logic [2:0] sha;
    logic [1:0] kind;
    always_comb
    begin
        ch   = 6'h00;
        se   = 6'h00;
        sha  = 3'h0;
        kind = codec_pkg::ST_CVBS;
        case (route_code)
            codec_pkg::RT_CV1:  begin ch = 6'h01; sha = 3'h1; end
            codec_pkg::RT_CV2:  begin ch = 6'h02; sha = 3'h1; end
            codec_pkg::RT_CV3:  begin ch = 6'h04; sha = 3'h2; end
            codec_pkg::RT_CV5:  begin ch = 6'h10; sha = 3'h1; end
            codec_pkg::RT_CV6:  begin ch = 6'h20; sha = 3'h4; end
            codec_pkg::RT_YC14: begin ch = 6'h09; sha = 3'h3; kind = codec_pkg::ST_YC; end
            codec_pkg::RT_YC23: begin ch = 6'h06; sha = 3'h3; kind = codec_pkg::ST_YC; end
            codec_pkg::RT_YUV:  begin ch = 6'h26; sha = 3'h7; kind = codec_pkg::ST_YUV; end
            codec_pkg::RT_AUX1: begin ch = 6'h3d; se = 6'h3c; sha = 3'h1; end
            codec_pkg::RT_AUX2: begin ch = 6'h3e; se = 6'h3c; sha = 3'h1; end
            default:            begin kind = codec_pkg::ST_NONE; end
        endcase
    end
    wire is_aux = (route_code == codec_pkg::RT_AUX1) || (route_code == codec_pkg::RT_AUX2);

    logic [1:0] kind_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_enable       <= 6'h00;
            channel_single_ended <= 6'h00;
            sha_enable           <= 3'h0;
            route_reserved       <= 1'b0;
            aux_enable           <= 1'b0;
            kind_reg             <= codec_pkg::ST_CVBS;
        end
        else
        begin
            channel_enable       <= ch;
            channel_single_ended <= se;
            sha_enable           <= sha;
            route_reserved       <= (kind == codec_pkg::ST_NONE);
            aux_enable           <= is_aux;
            kind_reg             <= kind;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Auxiliary sample tick: master clock rises divided by 32
    logic [codec_pkg::AUX_CNT_W-1:0] aux_cnt_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aux_cnt_reg <= '0;
            aux_tick    <= 1'b0;
        end
        else
        begin
            aux_tick <= 1'b0;
            if (mclk_rise && aux_enable)
            begin
                aux_cnt_reg <= aux_cnt_reg + 1'b1;
                aux_tick    <= &aux_cnt_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Digitizer output: top 10 of 12 bits, trim bits dropped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dout         <= 10'h000;
            chroma_phase <= 1'b0;
        end
        else if (mclk_rise)
        begin
            dout         <= adc_sample[codec_pkg::ADC_W-1:codec_pkg::TRIM_W];
            chroma_phase <= adc_chroma && (kind_reg == codec_pkg::ST_YC
                            || kind_reg == codec_pkg::ST_YUV);
        end
    end
endmodule

// ==== testbench/codec_monitor.sv ====
// Purpose: Port checks for the codec core
// Assumes: Bound to video_codec_core
// Notes:   Routing, overlay, divider, capture off
`timescale 1ns/10ps
module codec_monitor
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Inputs
    input wire logic [1:0] cap_mode,
    input wire logic [3:0] route_code,
    input wire logic [2:0] overlay_inputs,
    input wire logic       overlay_enable,
    input wire logic       master_clock_pin,
    // Outputs
    input wire logic [9:0] output_converter_0,
    input wire logic [9:0] output_converter_1,
    input wire logic [9:0] output_converter_2,
    input wire logic [9:0] output_converter_3,
    input wire logic       conv0_only,
    input wire logic [5:0] channel_enable,
    input wire logic [5:0] channel_single_ended,
    input wire logic [2:0] sha_enable,
    input wire logic       route_reserved,
    input wire logic       aux_enable,
    input wire logic       aux_tick
);
default clocking dc @(posedge clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////////////
logic [7:0] rise_cnt;
logic       mclk_d;
logic       seen;
wire logic  rise = master_clock_pin && !mclk_d;
always_ff @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        mclk_d   <= 1'b0;
        seen     <= 1'b0;
        rise_cnt <= 8'h00;
    end
    else
    begin
        mclk_d   <= master_clock_pin;
        seen     <= aux_enable && (seen || aux_tick);
        rise_cnt <= aux_tick ? 8'(rise) : rise_cnt + 8'(rise);
    end
end
////////////////////////////////////////////////////////////////////////////////
sequence s_code(logic [3:0] c);
    (route_code == c) [*6];
endsequence
sequence s_ovl;
    (overlay_enable && $stable(overlay_inputs)) [*4];
endsequence
property p_cv1;
    s_code(4'h0) |-> channel_enable == 6'h01 && sha_enable == 3'h1;
endproperty
a_cv1: assert property (p_cv1) else $error("cvbs routing wrong");
property p_rsvd;
    (route_code == 4'h3 || route_code > 4'ha) [*6]
        |-> route_reserved && channel_enable == 6'h00 && sha_enable == 3'h0;
endproperty
a_rsvd: assert property (p_rsvd) else $error("reserved code enabled");
property p_yc;
    s_code(4'h6) |-> channel_enable == 6'h09 && sha_enable == 3'h3;
endproperty
a_yc: assert property (p_yc) else $error("yc routing wrong");
property p_yuv;
    s_code(4'h8) |-> channel_enable == 6'h26 && sha_enable == 3'h7;
endproperty
a_yuv: assert property (p_yuv) else $error("component routing wrong");
property p_aux;
    s_code(4'h9) |-> aux_enable && channel_single_ended == 6'h3c && channel_enable == 6'h3d;
endproperty
a_aux: assert property (p_aux) else $error("aux routing wrong");
property p_ovl;
    s_ovl |-> output_converter_0 == {10{overlay_inputs[0]}}
        && output_converter_1 == {10{overlay_inputs[1]}}
        && output_converter_2 == {10{overlay_inputs[2]}};
endproperty
a_ovl: assert property (p_ovl) else $error("overlay not switched");
property p_off;
    (cap_mode == 2'h0 && !overlay_enable) [*6] |=> $stable(output_converter_0)
        && $stable(output_converter_1) && $stable(output_converter_2)
        && $stable(output_converter_3);
endproperty
a_off: assert property (p_off) else $error("write while capture off");
property p_single;
    $stable(cap_mode) [*6] |-> conv0_only == (cap_mode == 2'h0);
endproperty
a_single: assert property (p_single) else $error("single flag wrong");
property p_tick;
    aux_tick && seen |-> rise_cnt == 8'h20;
endproperty
a_tick: assert property (p_tick) else $error("aux divider wrong");
endmodule

// ==== testbench/video_source.sv ====
// Purpose: Video source driving the capture pins
// Assumes: Calls start just after a clk rise
// Notes:   Data inverted once its hold ends
`timescale 1ns/10ps
module video_source
(
    // Clock
    input  wire logic clk,
    // Capture pins
    output logic [9:0] conv_data,
    output logic       capture_strobe_clock,
    output logic       capture_marker_line,
    // Master clock
    output logic       master_clock_pin
);
initial
begin
    conv_data            = 10'h000;
    capture_strobe_clock = 1'b0;
    capture_marker_line  = 1'b0;
    master_clock_pin     = 1'b0;
    #7;
    forever #40 master_clock_pin = ~master_clock_pin;
end
task automatic put(input logic [9:0] d, input logic mk, input logic sc);
    conv_data = d;
    repeat (2) @(posedge clk);
    #1 capture_marker_line = mk;
    repeat (2) @(posedge clk);
    #1 capture_strobe_clock = sc;
    repeat (4) @(posedge clk);
    #1 conv_data = ~d;
    @(posedge clk);
    #1;
endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the codec core
// Assumes: 50 MHz clk, source model on capture pins
// Notes:   Capture modes, routing, overlay, divider, reset
`timescale 1ns/10ps
module testbench;
logic        clk = 1'b0;
logic        nrst = 1'b0;
logic [1:0]  cap_mode = 2'h0;
logic [3:0]  route_code = 4'h0;
logic [2:0]  ovl = 3'h0;
logic        ovl_en = 1'b0;
logic [11:0] adc = 12'h000;
logic        adc_c = 1'b0;
logic [9:0]  cd, dout, oc0, oc1, oc2, oc3;
logic [5:0]  en, se;
logic [2:0]  sha;
logic        sc, mk, mclk, c0, rsvd, aux, tick, cph;
int          fails = 0;
int          compares = 0;
always #10 clk = ~clk;
video_source src (.clk(clk), .conv_data(cd), .capture_strobe_clock(sc),
    .capture_marker_line(mk), .master_clock_pin(mclk));
video_codec_core uut (.clk(clk), .nrst(nrst), .cap_mode(cap_mode), .route_code(route_code),
    .conv_data(cd), .capture_strobe_clock(sc), .capture_marker_line(mk),
    .overlay_inputs(ovl), .overlay_enable(ovl_en), .master_clock_pin(mclk),
    .adc_sample(adc), .adc_chroma(adc_c), .output_converter_0(oc0),
    .output_converter_1(oc1), .output_converter_2(oc2), .output_converter_3(oc3),
    .conv0_only(c0), .channel_enable(en), .channel_single_ended(se), .sha_enable(sha),
    .route_reserved(rsvd), .aux_enable(aux), .aux_tick(tick), .dout(dout),
    .chroma_phase(cph));
////////////////////////////////////////////////////////////////////////////////
task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task check(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp)
    begin
        fails++;
        $display("CHECK FAILED at %0t: saw %h want %h", $time, got, exp);
    end
endtask
task results;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
function automatic logic [16:0] rt_exp(input logic [3:0] c);
    case (c)
        4'h0: rt_exp = {5'h01, 6'h00, 6'h01};
        4'h1: rt_exp = {5'h01, 6'h00, 6'h02};
        4'h2: rt_exp = {5'h02, 6'h00, 6'h04};
        4'h4: rt_exp = {5'h01, 6'h00, 6'h10};
        4'h5: rt_exp = {5'h04, 6'h00, 6'h20};
        4'h6: rt_exp = {5'h03, 6'h00, 6'h09};
        4'h7: rt_exp = {5'h03, 6'h00, 6'h06};
        4'h8: rt_exp = {5'h07, 6'h00, 6'h26};
        4'h9: rt_exp = {5'h09, 6'h3c, 6'h3d};
        4'ha: rt_exp = {5'h09, 6'h3c, 6'h3e};
        default: rt_exp = {5'h10, 6'h00, 6'h00};
    endcase
endfunction
////////////////////////////////////////////////////////////////////////////////
task t_route;
    for (int c = 0; c < 16; c++)
    begin
        route_code = 4'(c);
        wt(8);
        check(12'({rsvd, aux, sha}), 12'(rt_exp(4'(c)) >> 12));
        check({se, en}, 12'(rt_exp(4'(c))));
    end
endtask
task t_mode1;
    cap_mode = 2'h1;
    for (int i = 0; i < 5; i++)
    begin
        src.put(10'h101 + 10'(i), i == 0, 1'b1);
        src.put(10'h2f0, i == 0, 1'b0);
    end
    wt(6);
    check(12'(oc0), 12'h105);
    check(12'(oc1), 12'h102);
    check(12'(oc2), 12'h103);
    check(12'(oc3), 12'h104);
endtask
task t_mode2;
    cap_mode = 2'h2;
    src.put(10'h211, 1'b0, 1'b1);
    src.put(10'h222, 1'b1, 1'b1);
    src.put(10'h233, 1'b1, 1'b0);
    src.put(10'h244, 1'b0, 1'b0);
    wt(6);
    check({oc0, 2'h0}, 12'h844);
    check({oc1, 2'h0}, 12'h888);
    check({oc2, 2'h0}, 12'h8cc);
    check(12'(oc3), 12'h244);
endtask
task t_mode3;
    logic [9:0] w [4];
    w = '{10'h3c0, 10'h311, 10'h322, 10'h333};
    cap_mode = 2'h3;
    for (int i = 0; i < 4; i++)
    begin
        src.put(w[i], i == 0, 1'b1);
        src.put(w[i], i == 0, 1'b0);
    end
    wt(6);
    check(12'(oc2), 12'h3c0);
    check(12'(oc1), 12'h333);
    check(12'(oc0), 12'h322);
endtask
task t_off_ovl;
    cap_mode = 2'h0;
    src.put(10'h0aa, 1'b1, 1'b1);
    src.put(10'h0aa, 1'b0, 1'b0);
    wt(6);
    check(12'(oc0), 12'h322);
    check(12'(c0), 12'h001);
    ovl = 3'h5;
    ovl_en = 1'b1;
    wt(6);
    check({oc2, oc1[1:0]}, 12'hffc);
    check(12'(oc0), 12'h3ff);
    check(12'(oc3), 12'h244);
    ovl_en = 1'b0;
    wt(6);
    check(12'(oc1), 12'h333);
endtask
task t_aux;
    int n;
    route_code = 4'h9;
    n = 0;
    while (tick !== 1'b1 && n < 400)
    begin
        wt(1);
        n++;
    end
    wt(1);
    n = 1;
    while (tick !== 1'b1 && n < 400)
    begin
        wt(1);
        n++;
    end
    check(12'(n), 12'h080);
endtask
task t_adc;
    adc = 12'habc;
    adc_c = 1'b1;
    route_code = 4'h6;
    wt(16);
    check(12'(dout), 12'h2af);
    check(12'(cph), 12'h001);
    route_code = 4'h0;
    wt(16);
    check(12'(cph), 12'h000);
    route_code = 4'h8;
    wt(16);
    check(12'(cph), 12'h001);
endtask
task t_reset;
    nrst = 1'b0;
    wt(3);
    check(12'(oc0 | oc1 | oc2 | oc3), 12'h000);
    check(12'({dout, cph}), 12'h000);
    check({en, se}, 12'h000);
    nrst = 1'b1;
    wt(8);
    check(12'(en), 12'h026);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    wt(5);
    nrst = 1'b1;
    wt(3);
    t_route;
    t_mode1;
    t_mode2;
    t_mode3;
    t_off_ovl;
    t_aux;
    t_adc;
    t_reset;
    results;
end
initial
begin
    #200000;
    fails++;
    results;
end
endmodule
bind video_codec_core codec_monitor u_mon (.clk, .nrst, .cap_mode, .route_code,
    .overlay_inputs, .overlay_enable, .master_clock_pin, .output_converter_0,
    .output_converter_1, .output_converter_2, .output_converter_3, .conv0_only,
    .channel_enable, .channel_single_ended, .sha_enable, .route_reserved, .aux_enable,
    .aux_tick);
